// *** logic/ataeng_cfg.svh ***
// Register offsets, field positions, codes and record values for the card command engine
`ifndef ATAENG_CFG_SVH
`define ATAENG_CFG_SVH
`define AE_OFS_DATA   8'h00
`define AE_OFS_FEAT   8'h04
`define AE_OFS_SCNT   8'h08
`define AE_OFS_SNUM   8'h0c
`define AE_OFS_CYLL   8'h10
`define AE_OFS_CYLH   8'h14
`define AE_OFS_DRVH   8'h18
`define AE_OFS_CMD    8'h1c
`define AE_OFS_DCTL   8'h20
`define AE_OFS_MODE   8'h24
`define AE_ST_BSY     7
`define AE_ST_DRDY    6
`define AE_ST_DSC     4
`define AE_ST_DRQ     3
`define AE_ST_ERR     0
`define AE_DC_NIEN    1
`define AE_DC_SRST    2
`define AE_DH_LBA     6
`define AE_ER_ABRT    8'h04
`define AE_ER_IDNF    8'h10
`define AE_ER_UNC     8'h40
`define AE_DIAG_OK    8'h01
`define AE_SN_NONE    8'h00
`define AE_SN_ABORT   8'h20
`define AE_SN_RANGE   8'h21
`define AE_SN_MEDIA   8'h11
`define AE_SECT_WORDS 10'h100
`define AE_LONG_WORDS 10'h102
`define AE_ID_GENCFG  16'h848a
`define AE_ID_BYTES   16'h0200
`define AE_ID_BUFTYP  16'h0002
`define AE_ID_BUFSZ   16'h0002
`define AE_ID_ECCB    16'h0004
`define AE_ID_MAXMUL  16'h0001
`define AE_ID_CAPS    16'h0200
`define AE_ID_PIO     16'h0100
`define AE_ID_MULVAL  16'h0100
`define AE_FT_B8ON    8'h01
`define AE_FT_NOLA    8'h55
`define AE_FT_PORDIS  8'h66
`define AE_FT_B8OFF   8'h81
`define AE_FT_ECC4    8'hbb
`define AE_FT_PORENA  8'hcc
`endif

// *** logic/ataeng_pkg.sv ***
// Types shared by the card command engine
package ataeng_pkg;
	typedef enum logic [2:0] {AE_RESET, AE_READY, AE_EXEC, AE_FLASH, AE_XFER} ataeng_state_e;
endpackage : ataeng_pkg

// *** logic/ataeng_core.sv ***
// Card command engine: APB task file, command sequencing, power modes and identify record
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ataeng_cfg.svh"
// Notes on behaviour
// - Identify words 7 and 8 give total sectors, upper half first.
// - Identify declares a dual-ported buffer, its size, and four long check bytes.
// - Identify word 47 says one sector per multiple block at most.
// - Capabilities word: no DMA, LBA supported in bit 9.
// - Identify reports PIO mode 1 and zero DMA timing mode.
// - Words 60 and 61 hold the sector total reachable by LBA.
// - Idle sets busy, enters idle, interrupts; count nonzero enables auto power down.
// - Multiple reads and writes interrupt once per block, not per sector.
// - Long reads and writes move 516 bytes per sector.
// - Sector read moves 1 to 256 sectors, zero means 256, from sector number.
// - Sector write takes 1 to 256 sectors, zero means 256, from sector number.
// - Read verify reads like sector read but never raises data request.
// - Write verify checks each sector right after programming it.
// - Recalibrate group does nothing; seek group only checks the address range.
// - Request sense returns the extended error code of the last failure.
// - Set features code 01 enables byte transfers, 81 disables them.
// - Codes 66/CC gate soft reset defaults, 55 stops look-ahead, BB four check bytes.
// - Set multiple latches the block count and enables multiple commands only if it is nonzero.
// - Sleep and both standby commands set busy, sleep, clear busy, interrupt.
// - Wear level does nothing but leaves the sector count reading zero.
// - Write without erase forms program with no implicit erase.
// - Buffer read returns the sector buffer; buffer write overwrites it.
// - The host request follows completion only while interrupt disable is clear.
module ataeng_core #(
	parameter int CYLS       = 1000,
	parameter int HEADS      = 4,
	parameter int SPT        = 32,
	parameter int MAX_MULT   = 1,
	parameter int APD_CYCLES = 250000
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             host_irq,
	output logic             bsy,
	output logic             sleep,
	output logic             byte_mode,
	output logic      [8:0]  buf_addr,
	output logic      [15:0] buf_wdata,
	output logic             buf_we,
	input  wire logic [15:0] buf_rdata,
	output logic             fl_req,
	output logic             fl_prog,
	output logic             fl_erase,
	output logic             fl_verify,
	output logic      [27:0] fl_lba,
	input  wire logic        fl_done,
	input  wire logic        fl_err
);
	localparam logic [31:0] TOTAL = 32'(CYLS * HEADS * SPT);

	ataeng_pkg::ataeng_state_e state;
	logic [7:0]  feature, seccnt, secnum, drvh, cmd, errreg, sense, mult_cnt, blk_pos;
	logic [15:0] cyl, id_word;
	logic [8:0]  remain;
	logic [9:0]  wcnt;
	logic [23:0] apd_cnt;
	logic [7:0]  status, lo_byte;
	logic        drq, err, irq_pend, nien, srst, apd_en, por_dis, la_dis, ecc4, mult_en;

	// APB phases: acc is the taking edge, act the edge where pready is seen
	wire logic acc    = psel & penable & ~pready;
	wire logic act    = psel & penable & pready;
	wire logic wr_act = act & pwrite;
	wire logic rd_act = act & ~pwrite;
	wire logic tf_wr  = wr_act & ~bsy; // Task file is frozen while busy
	wire logic hit_data = paddr == `AE_OFS_DATA;
	wire logic hit_feat = paddr == `AE_OFS_FEAT;
	wire logic hit_scnt = paddr == `AE_OFS_SCNT;
	wire logic hit_snum = paddr == `AE_OFS_SNUM;
	wire logic hit_cyll = paddr == `AE_OFS_CYLL;
	wire logic hit_cylh = paddr == `AE_OFS_CYLH;
	wire logic hit_drvh = paddr == `AE_OFS_DRVH;
	wire logic hit_cmd  = paddr == `AE_OFS_CMD;
	wire logic hit_dctl = paddr == `AE_OFS_DCTL;
	wire logic hit_mode = paddr == `AE_OFS_MODE;
	wire logic hit_any  = hit_data | hit_feat | hit_scnt | hit_snum | hit_cyll | hit_cylh | hit_drvh
		| hit_cmd | hit_dctl | hit_mode;

	// Command classes
	wire logic c_rdn  = cmd == 8'h20 || cmd == 8'h21;
	wire logic c_rdl  = cmd == 8'h22 || cmd == 8'h23;
	wire logic c_rdm  = cmd == 8'hc4;
	wire logic c_rv   = cmd == 8'h40 || cmd == 8'h41;
	wire logic c_wrn  = cmd == 8'h30 || cmd == 8'h31;
	wire logic c_wrl  = cmd == 8'h32 || cmd == 8'h33;
	wire logic c_wrm  = cmd == 8'hc5;
	wire logic c_wrmn = cmd == 8'hcd;
	wire logic c_wrne = cmd == 8'h38;
	wire logic c_wv   = cmd == 8'h3c;
	wire logic c_id   = cmd == 8'hec;
	wire logic c_rbuf = cmd == 8'he4;
	wire logic c_wbuf = cmd == 8'he8;
	wire logic c_rcal = cmd[7:4] == 4'h1;
	wire logic c_seek = cmd[7:4] == 4'h7;
	wire logic c_sens = cmd == 8'h03;
	wire logic c_setf = cmd == 8'hef;
	wire logic c_setm = cmd == 8'hc6;
	wire logic c_idle = cmd == 8'he3 || cmd == 8'h97 || cmd == 8'he1 || cmd == 8'h95;
	wire logic c_slp  = cmd == 8'he6 || cmd == 8'h99 || cmd == 8'he2 || cmd == 8'h96 || cmd == 8'he0
		|| cmd == 8'h94;
	wire logic c_chk  = cmd == 8'he5 || cmd == 8'h98;
	wire logic c_init = cmd == 8'h91;
	wire logic c_diag = cmd == 8'h90;
	wire logic c_wear = cmd == 8'hf5;
	wire logic c_in   = c_rdn | c_rdl | c_rdm;
	wire logic c_out  = c_wrn | c_wrl | c_wrm | c_wrmn | c_wrne | c_wv;
	wire logic c_mul  = c_rdm | c_wrm | c_wrmn;
	wire logic c_long = c_rdl | c_wrl;
	wire logic known  = c_in | c_rv | c_out | c_id | c_rbuf | c_wbuf | c_rcal | c_seek | c_sens | c_setf
		| c_setm | c_idle | c_slp | c_chk | c_init | c_diag | c_wear;
	wire logic feat_ok = feature == `AE_FT_B8ON || feature == `AE_FT_NOLA || feature == `AE_FT_PORDIS
		|| feature == `AE_FT_B8OFF || feature == `AE_FT_ECC4 || feature == `AE_FT_PORENA;

	// Start address in either addressing form and its range check
	wire logic [31:0] chs = (32'(cyl) * 32'(HEADS) + 32'(drvh[3:0])) * 32'(SPT) + 32'(secnum) - 32'h0000_0001;
	wire logic [27:0] lba_start = drvh[`AE_DH_LBA] ? {drvh[3:0], cyl, secnum} : chs[27:0];
	wire logic range_ok = drvh[`AE_DH_LBA] ? ({4'h0, lba_start} < TOTAL)
		: (32'(cyl) < 32'(CYLS) && 32'(drvh[3:0]) < 32'(HEADS) && secnum != 8'h00 && 32'(secnum) <= 32'(SPT));
	wire logic bad = ~known | (c_mul & ~mult_en) | (c_setm & (32'(seccnt) > 32'(MAX_MULT)))
		| (c_setf & ~feat_ok) | (c_seek & ~range_ok);
	wire logic [8:0] cnt_eff = (seccnt == 8'h00) ? 9'h100 : {1'b0, seccnt};

	// Block position; plain commands use a block of one sector
	wire logic [7:0] bsz     = c_mul ? mult_cnt : 8'h01;
	wire logic [7:0] blk_inc = blk_pos + 8'h01;
	wire logic [7:0] blk_nxt = (blk_inc == bsz) ? 8'h00 : blk_inc;

	// Accesses per sector; byte mode doubles the count
	wire logic [9:0] words     = c_long ? `AE_LONG_WORDS : `AE_SECT_WORDS;
	wire logic [9:0] xfer_last = byte_mode ? {words[8:0], 1'b0} - 10'h001 : words - 10'h001;
	wire logic d_rd    = rd_act & hit_data & drq;
	wire logic d_wr    = wr_act & hit_data & drq & (c_out | c_wbuf);
	wire logic sec_end = (d_rd | d_wr) & (wcnt == xfer_last);
	wire logic [7:0] id_idx = byte_mode ? wcnt[8:1] : wcnt[7:0];

	// Identify record, built from geometry parameters and live settings
	always_comb begin
		case (id_idx)
			8'd0:    id_word = `AE_ID_GENCFG;
			8'd1:    id_word = 16'(CYLS);
			8'd3:    id_word = 16'(HEADS);
			8'd5:    id_word = `AE_ID_BYTES;
			8'd6:    id_word = 16'(SPT);
			8'd7:    id_word = TOTAL[31:16];
			8'd8:    id_word = TOTAL[15:0];
			8'd20:   id_word = `AE_ID_BUFTYP;
			8'd21:   id_word = `AE_ID_BUFSZ;
			8'd22:   id_word = `AE_ID_ECCB;
			8'd47:   id_word = `AE_ID_MAXMUL;
			8'd49:   id_word = `AE_ID_CAPS;
			8'd51:   id_word = `AE_ID_PIO;
			8'd59:   id_word = mult_en ? (`AE_ID_MULVAL | {8'h00, mult_cnt}) : 16'h0000;
			8'd60:   id_word = TOTAL[15:0];
			8'd61:   id_word = TOTAL[31:16];
			default: id_word = 16'h0000;
		endcase
	end

	// Status byte
	always_comb begin
		status = 8'h00;
		status[`AE_ST_BSY]  = bsy;
		status[`AE_ST_DRDY] = ~bsy;
		status[`AE_ST_DSC]  = 1'b1;
		status[`AE_ST_DRQ]  = drq;
		status[`AE_ST_ERR]  = err;
	end

	// Read data selection
	wire logic [15:0] dword = c_id ? id_word : buf_rdata;
	wire logic [15:0] dsel  = byte_mode ? {8'h00, wcnt[0] ? dword[15:8] : dword[7:0]} : dword;
	wire logic [31:0] rd_mux = hit_data ? {16'h0000, dsel}
		: hit_feat ? {24'h00_0000, errreg}
		: hit_scnt ? {24'h00_0000, seccnt}
		: hit_snum ? {24'h00_0000, secnum}
		: hit_cyll ? {24'h00_0000, cyl[7:0]}
		: hit_cylh ? {24'h00_0000, cyl[15:8]}
		: hit_drvh ? {24'h00_0000, drvh}
		: hit_cmd  ? {24'h00_0000, status}
		: hit_dctl ? {29'h0000_0000, srst, nien, 1'b0}
		: hit_mode ? {16'h0000, mult_cnt, 1'b0, mult_en, ecc4, la_dis, por_dis, apd_en, byte_mode, sleep}
		: 32'h0000_0000;

	// APB answer: one wait state so read data comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc;
			pslverr <= acc & ~hit_any;
			if (acc & ~pwrite)
				prdata <= rd_mux;
		end
	end

	// Device control is writable even while busy, so reset can always get in
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nien <= 1'b0;
			srst <= 1'b0;
		end else if (wr_act & hit_dctl) begin
			nien <= pwdata[`AE_DC_NIEN];
			srst <= pwdata[`AE_DC_SRST];
		end
	end

	// Host request line; the mask gates it, the pending flag survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			host_irq <= 1'b0;
		else
			host_irq <= irq_pend & ~nien;
	end

	// Buffer port; address lags the counter so a write pairs with its own slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_addr  <= 9'h000;
			buf_we    <= 1'b0;
			buf_wdata <= 16'h0000;
			lo_byte   <= 8'h00;
		end else begin
			buf_addr <= byte_mode ? wcnt[9:1] : wcnt[8:0];
			buf_we   <= d_wr & (~byte_mode | wcnt[0]);
			if (d_wr & byte_mode & ~wcnt[0])
				lo_byte <= pwdata[7:0];
			if (d_wr)
				buf_wdata <= byte_mode ? {pwdata[7:0], lo_byte} : pwdata[15:0];
		end
	end

	// Task file and command sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ataeng_pkg::AE_READY;
			{feature, seccnt, secnum, drvh, cmd, errreg, mult_cnt, blk_pos} <= 64'h0000_0000_0000_0000;
			sense <= `AE_SN_NONE;
			cyl <= 16'h0000;
			remain <= 9'h000;
			wcnt <= 10'h000;
			apd_cnt <= 24'h00_0000;
			{bsy, drq, err, irq_pend, sleep, apd_en, byte_mode, por_dis, la_dis, ecc4, mult_en} <= 11'h000;
			{fl_req, fl_prog, fl_erase, fl_verify} <= 4'h0;
			fl_lba <= 28'h000_0000;
		end else if (srst) begin
			state <= ataeng_pkg::AE_RESET;
			{bsy, drq, err, irq_pend, fl_req} <= 5'h10;
			wcnt <= 10'h000;
			if (!por_dis) begin
				{apd_en, byte_mode, la_dis, ecc4, mult_en} <= 5'h00;
				mult_cnt <= 8'h00;
			end
		end else begin
			if (rd_act & hit_cmd)
				irq_pend <= 1'b0; // Status read acknowledges
			if (tf_wr & hit_feat)
				feature <= pwdata[7:0];
			if (tf_wr & hit_scnt)
				seccnt <= pwdata[7:0];
			if (tf_wr & hit_snum)
				secnum <= pwdata[7:0];
			if (tf_wr & hit_cyll)
				cyl[7:0] <= pwdata[7:0];
			if (tf_wr & hit_cylh)
				cyl[15:8] <= pwdata[7:0];
			if (tf_wr & hit_drvh)
				drvh <= pwdata[7:0];
			if (tf_wr & hit_cmd) begin
				cmd <= pwdata[7:0];
				{bsy, err, irq_pend, drq} <= 4'h8;
				errreg <= 8'h00;
				apd_cnt <= 24'h00_0000;
				state <= ataeng_pkg::AE_EXEC;
			end
			case (state)
				ataeng_pkg::AE_RESET: begin
					bsy <= 1'b0;
					state <= ataeng_pkg::AE_READY;
				end
				ataeng_pkg::AE_READY: begin
					// Automatic power down after a quiet spell
					if (apd_en & ~sleep & ~(tf_wr & hit_cmd)) begin
						if (apd_cnt == 24'(APD_CYCLES - 1))
							sleep <= 1'b1;
						else
							apd_cnt <= apd_cnt + 24'h00_0001;
					end
				end
				ataeng_pkg::AE_EXEC: begin
					remain <= cnt_eff;
					fl_lba <= lba_start;
					blk_pos <= 8'h00;
					wcnt <= 10'h000;
					fl_erase <= c_out & ~(c_wrmn | c_wrne);
					fl_verify <= c_wv;
					sleep <= c_slp & ~bad;
					if (bad) begin
						{bsy, err, irq_pend} <= 3'b011;
						errreg <= c_seek ? `AE_ER_IDNF : `AE_ER_ABRT;
						sense <= c_seek ? `AE_SN_RANGE : `AE_SN_ABORT;
						sleep <= sleep;
						state <= ataeng_pkg::AE_READY;
					end else if (c_in | c_rv) begin
						{fl_req, fl_prog} <= 2'b10;
						state <= ataeng_pkg::AE_FLASH;
					end else if (c_out | c_id | c_rbuf | c_wbuf) begin
						{bsy, drq} <= 2'b01;
						irq_pend <= c_id | c_rbuf;
						state <= ataeng_pkg::AE_XFER;
					end else begin
						{bsy, irq_pend} <= 2'b01;
						state <= ataeng_pkg::AE_READY;
						if (c_idle & (cmd == 8'he3 || cmd == 8'h97))
							apd_en <= seccnt != 8'h00;
						if (c_chk)
							seccnt <= sleep ? 8'h00 : 8'hff;
						if (c_sens) begin
							errreg <= sense;
							sense <= `AE_SN_NONE;
						end
						if (c_setm) begin
							mult_en <= seccnt != 8'h00;
							mult_cnt <= seccnt;
						end
						if (c_wear)
							seccnt <= 8'h00;
						if (c_diag)
							errreg <= `AE_DIAG_OK;
						if (c_setf) begin
							if (feature == `AE_FT_B8ON)
								byte_mode <= 1'b1;
							if (feature == `AE_FT_B8OFF)
								byte_mode <= 1'b0;
							if (feature == `AE_FT_PORDIS)
								por_dis <= 1'b1;
							if (feature == `AE_FT_PORENA)
								por_dis <= 1'b0;
							if (feature == `AE_FT_NOLA)
								la_dis <= 1'b1;
							if (feature == `AE_FT_ECC4)
								ecc4 <= 1'b1;
						end
					end
				end
				ataeng_pkg::AE_FLASH: begin
					if (fl_done) begin
						fl_req <= 1'b0;
						if (fl_err) begin
							{bsy, err, irq_pend} <= 3'b011;
							errreg <= `AE_ER_UNC;
							sense <= `AE_SN_MEDIA;
							state <= ataeng_pkg::AE_READY;
						end else if (!fl_prog & c_in) begin
							{bsy, drq} <= 2'b01;
							if (blk_pos == 8'h00)
								irq_pend <= 1'b1;
							state <= ataeng_pkg::AE_XFER;
						end else begin
							// Verify read or program finished: one sector done
							remain <= remain - 9'h001;
							fl_lba <= fl_lba + 28'h000_0001;
							blk_pos <= blk_nxt;
							if (remain == 9'h001) begin
								{bsy, irq_pend} <= 2'b01;
								state <= ataeng_pkg::AE_READY;
							end else if (c_rv) begin
								fl_req <= 1'b1;
							end else begin
								{bsy, drq} <= 2'b01;
								if (blk_nxt == 8'h00)
									irq_pend <= 1'b1;
								state <= ataeng_pkg::AE_XFER;
							end
						end
					end
				end
				ataeng_pkg::AE_XFER: begin
					if (d_rd | d_wr)
						wcnt <= wcnt + 10'h001;
					if (sec_end) begin
						drq <= 1'b0;
						wcnt <= 10'h000;
						if (c_out) begin
							{bsy, fl_req, fl_prog} <= 3'b111;
							state <= ataeng_pkg::AE_FLASH;
						end else if (c_in & (remain != 9'h001)) begin
							{bsy, fl_req, fl_prog} <= 3'b110;
							remain <= remain - 9'h001;
							fl_lba <= fl_lba + 28'h000_0001;
							blk_pos <= blk_nxt;
							state <= ataeng_pkg::AE_FLASH;
						end else begin
							irq_pend <= c_wbuf;
							state <= ataeng_pkg::AE_READY;
						end
					end
				end
				default: state <= ataeng_pkg::AE_READY;
			endcase
		end
	end

	default clocking ae_cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	cmd_busy_a: assert property ((tf_wr && hit_cmd) |=> bsy && state == ataeng_pkg::AE_EXEC)
		else $error("command write did not raise busy");
	abort_flags_a: assert property ((state == ataeng_pkg::AE_EXEC && bad && !c_seek)
		|=> err && !bsy && irq_pend && errreg == `AE_ER_ABRT)
		else $error("bad command did not abort");
	irq_mask_a: assert property (nien ##1 nien |-> !host_irq)
		else $error("request raised while disabled");
	verify_nodrq_a: assert property ((c_rv && state != ataeng_pkg::AE_READY) |-> !drq)
		else $error("data request during read verify");
	zero_count_a: assert property ((state == ataeng_pkg::AE_EXEC && (c_in || c_rv) && seccnt == 8'h00 && !bad)
		|=> remain == 9'h100)
		else $error("zero count not taken as 256");
	long_len_a: assert property ((c_long && !byte_mode) |-> xfer_last == 10'h101)
		else $error("long sector length wrong");
	wear_zero_a: assert property ((state == ataeng_pkg::AE_EXEC && c_wear && !bad) |=> seccnt == 8'h00)
		else $error("wear level left count nonzero");
	byte_feat_a: assert property ((state == ataeng_pkg::AE_EXEC && c_setf && feature == `AE_FT_B8ON)
		|=> byte_mode ##1 $stable(byte_mode))
		else $error("byte mode not enabled");
	no_erase_a: assert property ((fl_req && fl_prog && (c_wrmn || c_wrne)) |-> !fl_erase)
		else $error("erase requested on no-erase write");
	block_irq_a: assert property ((state == ataeng_pkg::AE_FLASH && fl_done && !fl_err && c_rdm
		&& blk_pos != 8'h00 && !irq_pend && !nien) |=> !irq_pend ##1 !host_irq)
		else $error("interrupt inside a block");
	sleep_cmd_a: assert property ((state == ataeng_pkg::AE_EXEC && c_slp && !bad)
		|=> sleep && !bsy && irq_pend)
		else $error("sleep command sequence wrong");
	ident_hi_a: assert property ((c_id && drq && id_idx == 8'd7) |-> dword == TOTAL[31:16])
		else $error("identify size word wrong");

	read_multi_c: cover property (state == ataeng_pkg::AE_XFER && c_rdm && blk_pos != 8'h00);
	identify_end_c: cover property (sec_end && c_id);
	abort_c: cover property (state == ataeng_pkg::AE_EXEC && bad);
	write_verify_c: cover property (fl_req && fl_prog && fl_verify && fl_done);
endmodule : ataeng_core

// *** bench/ataeng_far.sv ***
// Far-side model for the card command engine: sector buffer and flash responder
`timescale 1ns/1ps
module ataeng_far (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [8:0]  buf_addr,
	input  wire logic [15:0] buf_wdata,
	input  wire logic        buf_we,
	output logic      [15:0] buf_rdata,
	input  wire logic        fl_req,
	input  wire logic [3:0]  fl_lat,
	output logic             fl_done
);
	logic [15:0] mem [0:511];
	logic [3:0]  cnt;
	// Buffer read is combinational, as the engine expects
	assign buf_rdata = mem[buf_addr];
	// Buffer store
	always_ff @(posedge pclk) begin
		if (buf_we) begin
			mem[buf_addr] <= buf_wdata;
		end
	end
	// Flash answers fl_lat + 1 cycles into a request; done is never given without a request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			fl_done <= 1'b0;
		end else begin
			fl_done <= fl_req && !fl_done && (cnt == fl_lat);
			cnt <= (fl_req && !fl_done && cnt != fl_lat) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule : ataeng_far

// *** bench/ata_card_command_engine_tb.sv ***
// Testbench for the card command engine: APB host, far-side model and scenario tasks
`timescale 1ns/1ps
`include "ataeng_cfg.svh"
module ata_card_command_engine_tb;
	localparam logic [31:0] TOT = 32'h0000_0040;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        fl_err = 1'b0;
	logic [3:0]  fl_lat = 4'h3;
	logic        qerr;
	logic [31:0] prdata, q;
	logic        pready, pslverr, host_irq, bsy, sleep, byte_mode, buf_we, fl_req, fl_prog, fl_erase, fl_verify, fl_done;
	logic [8:0]  buf_addr;
	logic [15:0] buf_wdata, buf_rdata;
	logic [27:0] fl_lba;
	logic [30:0] ops [$];
	logic [15:0] idw [0:255];
	int          n_fail = 0;
	int          total_checks = 0;
	always #2 pclk = ~pclk;
	ataeng_core #(.CYLS(4), .HEADS(2), .SPT(8), .MAX_MULT(2), .APD_CYCLES(20)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .host_irq(host_irq), .bsy(bsy), .sleep(sleep),
		.byte_mode(byte_mode), .buf_addr(buf_addr), .buf_wdata(buf_wdata), .buf_we(buf_we), .buf_rdata(buf_rdata),
		.fl_req(fl_req), .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_verify(fl_verify), .fl_lba(fl_lba),
		.fl_done(fl_done), .fl_err(fl_err));
	ataeng_far u_far (.pclk(pclk), .presetn(presetn), .buf_addr(buf_addr), .buf_wdata(buf_wdata),
		.buf_we(buf_we), .buf_rdata(buf_rdata), .fl_req(fl_req), .fl_lat(fl_lat), .fl_done(fl_done));
	// Log each finished flash operation with its kind and sector
	always @(posedge pclk) begin
		if (fl_req && fl_done) ops.push_back({fl_prog, fl_erase, fl_verify, fl_lba});
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One APB transfer; the request stands until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		qerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) chk("pready", 1, 0);
		if (n >= 20) final_report();
	endtask : apb
	// Bounded wait for busy to fall; long bound covers a 256-sector verify
	task automatic settle();
		int n;
		n = 0;
		repeat (3) @(posedge pclk);
		while (bsy !== 1'b0 && n < 8000) begin
			@(posedge pclk);
			n++;
		end
		#1;
		if (n >= 8000) chk("busy", 0, 1);
		if (n >= 8000) final_report();
	endtask : settle
	task automatic cmd(input logic [7:0] c);
		apb(1'b1, `AE_OFS_CMD, {24'h00_0000, c});
		settle();
	endtask : cmd
	task automatic xfer(input logic w, input int n);
		for (int i = 0; i < n; i++) begin
			apb(w, `AE_OFS_DATA, 32'h0000_a000 + i);
			idw[i[7:0]] = q[15:0];
		end
		settle();
	endtask : xfer
	task automatic reg_is(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, q & m);
	endtask : reg_is
	task automatic t_ident();
		cmd(8'hec);
		xfer(1'b0, 256);
		chk("id_cfg", 32'h0000_848a, {16'h0000, idw[0]});
		chk("id_total", TOT, {idw[7], idw[8]});
		chk("id_buf", 32'h0002_0002, {idw[20], idw[21]});
		chk("id_ecc", 32'h0000_0004, {16'h0000, idw[22]});
		chk("id_mult", 32'h0000_0001, {16'h0000, idw[47]});
		chk("id_caps", 32'h0000_0200, {16'h0000, idw[49]});
		chk("id_pio", 32'h0100_0000, {idw[51], idw[52]});
		chk("id_lba", TOT, {idw[61], idw[60]});
		reg_is("drq_end", `AE_OFS_CMD, 32'h0000_0089, 32'h0000_0000);
	endtask : t_ident
	task automatic t_power();
		logic [7:0] pc [3] = '{8'he6, 8'he2, 8'he0};
		apb(1'b1, `AE_OFS_SCNT, 32'h0000_0001);
		cmd(8'he3);
		@(posedge pclk);
		chk("irq_idle", 1, host_irq);
		reg_is("apd_on", `AE_OFS_MODE, 32'h0000_0004, 32'h0000_0004);
		apb(1'b1, `AE_OFS_SCNT, 32'h0000_0000);
		cmd(8'he3);
		reg_is("apd_off", `AE_OFS_MODE, 32'h0000_0004, 32'h0000_0000);
		apb(1'b1, `AE_OFS_DCTL, 32'h0000_0002);
		cmd(8'he1);
		@(posedge pclk);
		chk("irq_masked", 0, host_irq);
		apb(1'b1, `AE_OFS_DCTL, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		chk("irq_unmasked", 1, host_irq);
		for (int i = 0; i < 3; i++) begin
			cmd(pc[i]);
			chk("sleep", 1, sleep);
			cmd(8'he1);
			chk("wake", 0, sleep);
		end
	endtask : t_power
	task automatic t_feat();
		logic [7:0] fc [6] = '{8'h01, 8'h81, 8'h55, 8'hbb, 8'h66, 8'hcc};
		int         fb [6] = '{1, 1, 4, 5, 3, 3};
		logic [5:0] fv = 6'b10_1110;
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, `AE_OFS_FEAT, {24'h00_0000, fc[i]});
			cmd(8'hef);
			reg_is("feature", `AE_OFS_MODE, 32'h0000_0001 << fb[i], {31'h0, fv[5 - i]} << fb[i]);
		end
		chk("byte_mode", 0, byte_mode);
		apb(1'b1, `AE_OFS_SCNT, 32'h0000_0001);
		cmd(8'hc6);
		reg_is("set_mult", `AE_OFS_MODE, 32'h0000_ff40, 32'h0000_0140);
		apb(1'b1, `AE_OFS_DCTL, 32'h0000_0004);
		apb(1'b1, `AE_OFS_DCTL, 32'h0000_0000);
		settle();
		reg_is("srst_dflt", `AE_OFS_MODE, 32'h0000_ff76, 32'h0000_0000);
	endtask : t_feat
	task automatic t_err();
		cmd(8'hc0);
		reg_is("abort_st", `AE_OFS_CMD, 32'h0000_0089, 32'h0000_0001);
		reg_is("abort_err", `AE_OFS_FEAT, 32'h0000_00ff, {24'h0, `AE_ER_ABRT});
		cmd(8'h03);
		reg_is("sense", `AE_OFS_FEAT, 32'h0000_00ff, {24'h0, `AE_SN_ABORT});
		cmd(8'h15);
		reg_is("recal", `AE_OFS_CMD, 32'h0000_0089, 32'h0000_0000);
		apb(1'b1, `AE_OFS_CYLH, 32'h0000_00ff);
		cmd(8'h70);
		reg_is("seek_err", `AE_OFS_FEAT, 32'h0000_00ff, {24'h0, `AE_ER_IDNF});
		apb(1'b1, `AE_OFS_CYLH, 32'h0000_0000);
		apb(1'b1, `AE_OFS_SCNT, 32'h0000_0005);
		cmd(8'hf5);
		reg_is("wear", `AE_OFS_SCNT, 32'h0000_00ff, 32'h0000_0000);
		apb(1'b0, 8'h28, 32'h0000_0000);
		chk("slverr", 1, qerr);
	endtask : t_err
	task automatic t_data();
		logic [7:0] wc [3] = '{8'h30, 8'h38, 8'h3c};
		logic [2:0] wf [3] = '{3'b110, 3'b100, 3'b111};
		cmd(8'he8);
		xfer(1'b1, 256);
		cmd(8'he4);
		xfer(1'b0, 256);
		for (int i = 0; i < 256; i += 51) chk("buffer", 32'h0000_a000 + i, {16'h0, idw[i]});
		apb(1'b1, `AE_OFS_DRVH, 32'h0000_0040);
		apb(1'b1, `AE_OFS_SNUM, 32'h0000_0005);
		apb(1'b1, `AE_OFS_SCNT, 32'h0000_0002);
		ops.delete();
		cmd(8'h20);
		xfer(1'b0, 256);
		xfer(1'b0, 256);
		chk("rd_lba", {3'b000, 28'h000_0006}, ops[ops.size() - 1]);
		chk("rd_ops", 2, ops.size());
		fl_lat <= 4'h0;
		apb(1'b1, `AE_OFS_SCNT, 32'h0000_0000);
		cmd(8'h40);
		reg_is("vfy_drq", `AE_OFS_CMD, 32'h0000_0089, 32'h0000_0000);
		chk("vfy_ops", 258, ops.size());
		apb(1'b1, `AE_OFS_SCNT, 32'h0000_0002);
		cmd(8'hc6);
		cmd(8'hc4);
		reg_is("blk_start", `AE_OFS_CMD, 32'h0000_0089, 32'h0000_0008);
		xfer(1'b0, 256);
		chk("blk_irq", 0, host_irq);
		xfer(1'b0, 256);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `AE_OFS_SCNT, 32'h0000_0001);
			cmd(wc[i]);
			xfer(1'b1, 256);
			chk("wr_op", {wf[i], 28'h000_0005}, ops[ops.size() - 1]);
		end
		cmd(8'h22);
		xfer(1'b0, 257);
		reg_is("long_drq", `AE_OFS_CMD, 32'h0000_0089, 32'h0000_0008);
		xfer(1'b0, 1);
		reg_is("long_end", `AE_OFS_CMD, 32'h0000_0089, 32'h0000_0000);
		fl_err <= 1'b1;
		cmd(8'h20);
		fl_err <= 1'b0;
		reg_is("media_err", `AE_OFS_FEAT, 32'h0000_00ff, {24'h0, `AE_ER_UNC});
	endtask : t_data
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_ident();
		t_power();
		t_feat();
		t_err();
		t_data();
		final_report();
	end
endmodule : ata_card_command_engine_tb
